// ===== src/key_matrix_scanner.sv
// Key matrix scanner with a classic Wishbone register port.
// Assumes synchronous row inputs and an LCD segment waveform on seg_lcd_i.
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - The first sixteen segment pins carry the scan columns in a short slot without disturbing the LCD image.
// - The 8-bit scan configuration loads as an immediate byte, as two nibbles, or as a table byte.
// - With bit 6 clear and the wake enable set, a key press raises the wake request and the start flag in the same cycle.
// - With bit 6 set and the wake enable set, every scan cycle end raises the wake request and the start flag in the same cycle.
// - Mode 000 drives only the single column chosen by bits 3 to 0.
// - Mode 001 drives all sixteen columns at once.
// - Mode 010 turns scanning off.
// - Mode 10x drives columns 1-8 or 9-16 by bit 3.
// - Mode 110 drives a group of four columns chosen by bits 3 and 2.
// - Mode 111 drives a pair of columns chosen by bits 3 to 1.
// - Any row going high inside the scan slot sets the wake request, and with the enable set also the start flag and a halt release.
// - At each scan cycle end the four rows are latched for software to read.
// - Clearing with mask bit 5 clears the wake request.
// - The scan rate is frame frequency times duty phases times two.
module key_matrix_scanner
   import key_scan_pkg::*;
#(
   parameter int unsigned FRAME_HZ    = FRAME_HZ_DEF,
   parameter int unsigned DUTY        = DUTY_DEF,
   parameter int unsigned SCAN_CYCLES = CLK_HZ / (FRAME_HZ * DUTY * SCAN_FACTOR),
   parameter int unsigned WINDOW      = KEY_WINDOW_CYCLES
) (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // Wishbone slave
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [7:0]             adr_i,
   input  wire logic [31:0]            dat_i,
   output logic                        ack_o,
   output logic [31:0]                 dat_o,
   // Key matrix and LCD segments
   input  wire logic [NUM_ROWS-1:0]    row_i,
   input  wire logic [NUM_COLUMNS-1:0] seg_lcd_i,
   output logic [NUM_COLUMNS-1:0]      column_o,
   // Wake and interrupt
   output logic                        halt_release_o,
   output logic                        irq_o
);
   if (DUTY < 1 || FRAME_HZ < 1 || SCAN_CYCLES < 2) begin : g_bad_rate
      $error("scan timing parameters out of range");
   end

   wb_req_s                  req;
   scan_cfg_s                cfg_reg;
   logic [NUM_ROWS-1:0]      row_latch_reg;
   logic [NUM_ROWS-1:0]      row_prev_reg;
   logic                     key_wake_enable_reg;
   logic [ST_WIDTH-1:0]      status_reg;
   logic [ST_WIDTH-1:0]      mask_reg;
   logic                     ack_reg;
   logic [31:0]              dat_reg;
   logic [NUM_COLUMNS-1:0]   cols_sel;
   logic                     scan_on;
   logic                     window;
   logic                     cycle_end;
   logic                     drive;
   logic                     key_rise;
   logic                     wake_set;
   logic                     start_set;
   logic                     wr_now;
   logic [ST_WIDTH-1:0]      wr_clear;
   logic [ST_WIDTH-1:0]      set_vec;

   assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

   // Configuration to column set
   column_decode u_decode (
      .cfg_i     (cfg_reg),
      .columns_o (cols_sel),
      .scan_on_o (scan_on)
   );

   // Scan period derived from frame rate and duty
   scan_timer #(
      .PERIOD (SCAN_CYCLES),
      .WINDOW (WINDOW)
   ) u_timer (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .window_o    (window),
      .cycle_end_o (cycle_end)
   );

   // Columns borrow the segment pins only inside the scan slot; outside
   // it the LCD waveform passes untouched so the image is kept
   assign drive    = window && scan_on;
   assign column_o = drive ? cols_sel : seg_lcd_i;

   // Register bus handshake: take the request, answer one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req.cyc && req.stb && !ack_reg;
      end
   end
   assign ack_o  = ack_reg;
   assign wr_now = ack_reg && req.cyc && req.stb && req.we && req.sel[0];

   // Read data, registered when the request is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= '0;
      end else if (req.cyc && req.stb && !ack_reg) begin
         case (req.adr)
            ADDR_CFG_IMM,
            ADDR_CFG_NIB,
            ADDR_CFG_TABLE: dat_reg <= {24'h0, cfg_reg};
            ADDR_ROW_LATCH: dat_reg <= {28'h0, row_latch_reg};
            ADDR_WAKE_EN:   dat_reg <= {31'h0, key_wake_enable_reg};
            ADDR_STATUS:    dat_reg <= {26'h0, status_reg};
            ADDR_MASK:      dat_reg <= {26'h0, mask_reg};
            default:        dat_reg <= '0;
         endcase
      end
   end
   assign dat_o = dat_reg;

   // Scan configuration: three load paths, one byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= CFG_RESET;
      end else if (wr_now) begin
         case (req.adr)
            ADDR_CFG_IMM:   cfg_reg <= req.dat[7:0];
            ADDR_CFG_NIB:   cfg_reg <= {req.dat[7:4], req.dat[3:0]};
            ADDR_CFG_TABLE: cfg_reg <= req.dat[7:0];
            default:        cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Wake enable and interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_wake_enable_reg <= 1'b0;
         mask_reg            <= '0;
      end else if (wr_now) begin
         if (req.adr == ADDR_WAKE_EN) begin
            key_wake_enable_reg <= req.dat[0];
         end
         if (req.adr == ADDR_MASK) begin
            mask_reg <= req.dat[ST_WIDTH-1:0] & ST_IMPL;
         end
      end
   end

   // Row edge tracker; cleared outside the slot so a held key counts again
   always_ff @(posedge clk_i) begin
      if (rst_i || !drive) begin
         row_prev_reg <= '0;
      end else begin
         row_prev_reg <= row_i;
      end
   end
   assign key_rise = drive && |(row_i & ~row_prev_reg);

   // Row latch, taken at the end of each scan slot
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         row_latch_reg <= '0;
      end else if (cycle_end && scan_on) begin
         row_latch_reg <= row_i;
      end
   end

   // Wake events per mode
   assign wake_set  = key_rise ||
                      (cycle_end && scan_on && cfg_reg.wake_every_cycle_select
                       && key_wake_enable_reg);
   assign start_set = wake_set && key_wake_enable_reg;

   // Write one to clear; a set in the same cycle wins
   assign wr_clear = (wr_now && req.adr == ADDR_STATUS) ? req.dat[ST_WIDTH-1:0] : '0;
   always_comb begin
      set_vec = '0;
      set_vec[ST_WAKE_BIT]  = wake_set;
      set_vec[ST_START_BIT] = start_set;
      set_vec[ST_SCAN_BIT]  = cycle_end && scan_on;
   end

   // Sticky status flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= '0;
      end else begin
         status_reg <= ((status_reg & ~wr_clear) | set_vec) & ST_IMPL;
      end
   end

   // Halt release while an enabled wake request stands; interrupt by mask
   assign halt_release_o = status_reg[ST_WAKE_BIT] && key_wake_enable_reg;
   assign irq_o          = |(status_reg & mask_reg);

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_wb_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_status_clear;
      wr_now && adr_i == ADDR_STATUS && dat_i[ST_WAKE_BIT];
   endsequence

   a_wb_ack_one: assert property (s_wb_take |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle after take");
   a_col_single: assert property (drive && column_group_mode(cfg_reg) == GRP_SINGLE
                                  |-> column_o == (16'h0001 << cfg_reg.sel))
      else $error("single column mode drives wrong column");
   a_col_all: assert property (drive && column_group_mode(cfg_reg) == GRP_ALL
                               |-> column_o == 16'hffff)
      else $error("all column mode not driving all columns");
   a_scan_off: assert property (column_group_mode(cfg_reg) == GRP_OFF
                                |-> column_o == seg_lcd_i && !key_rise)
      else $error("disabled scan still drives columns");
   a_col_eight: assert property (drive && cfg_reg.mode_hi && !cfg_reg.mode_lo[1]
                                 |-> $countones(column_o) == 8)
      else $error("eight column group wrong size");
   a_col_quad: assert property (drive && column_group_mode(cfg_reg) == GRP_QUAD
                                |-> column_o == (16'h000f << {cfg_reg.sel[3:2], 2'h0}))
      else $error("four column group wrong");
   a_col_pair: assert property (drive && column_group_mode(cfg_reg) == GRP_PAIR
                                |-> $countones(column_o) == 2)
      else $error("two column group wrong size");
   a_lcd_pass: assert property (!window |-> column_o == seg_lcd_i)
      else $error("segment waveform disturbed outside scan slot");
   a_key_wake: assert property (key_rise |=> status_reg[ST_WAKE_BIT])
      else $error("key press did not raise wake request");
   a_start_flag: assert property (key_rise && key_wake_enable_reg
                                  |=> status_reg[ST_START_BIT] && halt_release_o)
      else $error("enabled key press did not set start flag");
   a_every_cycle: assert property (cycle_end && scan_on && cfg_reg.wake_every_cycle_select
                                   && key_wake_enable_reg |=> status_reg[ST_WAKE_BIT])
      else $error("every cycle wake missing");
   a_row_latch: assert property (cycle_end && scan_on |=> row_latch_reg == $past(row_i))
      else $error("row latch not taken at cycle end");
   a_wake_clear: assert property (s_status_clear and !wake_set |=> !status_reg[ST_WAKE_BIT])
      else $error("wake request not cleared");
   a_set_wins: assert property (s_status_clear and wake_set |=> status_reg[ST_WAKE_BIT])
      else $error("clear overrode a new wake event");
   a_cfg_load: assert property (wr_now && adr_i == ADDR_CFG_IMM |=> cfg_reg == $past(dat_i[7:0]))
      else $error("configuration byte not loaded");

   // Assertion helpers. Both counters saturate, so a long run with a stopped
   // timer cannot wrap them round into a false match
   localparam int unsigned   PW          = $clog2(SCAN_CYCLES + 1);
   localparam logic [PW-1:0] PERIOD_LAST = PW'(SCAN_CYCLES - 1);
   localparam logic [PW-1:0] SLOT_LAST   = PW'(WINDOW - 1);

   logic [PW-1:0]            since_end_reg;
   logic [PW-1:0]            slot_len_reg;
   logic                     seen_end_reg;

   // Cycles since the last slot end
   always_ff @(posedge clk_i) begin
      if (rst_i || cycle_end) begin
         since_end_reg <= '0;
      end else if (!(&since_end_reg)) begin
         since_end_reg <= since_end_reg + 1'b1;
      end
   end

   // The first slot end after reset has no full period behind it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen_end_reg <= 1'b0;
      end else if (cycle_end) begin
         seen_end_reg <= 1'b1;
      end
   end

   // Cycles spent inside the current scan slot
   always_ff @(posedge clk_i) begin
      if (rst_i || !window) begin
         slot_len_reg <= '0;
      end else if (!(&slot_len_reg)) begin
         slot_len_reg <= slot_len_reg + 1'b1;
      end
   end

   // A slot of the set length, then the segment waveform again
   sequence s_slot_closes;
      slot_len_reg == SLOT_LAST ##1 !window;
   endsequence

   a_scan_period: assert property (cycle_end && seen_end_reg |-> since_end_reg == PERIOD_LAST)
      else $error("scan period differs from the set rate");
   a_slot_len: assert property (cycle_end |-> s_slot_closes)
      else $error("scan slot length wrong");
   // Without the enable no key event may raise the start flag
   a_start_needs_en: assert property (!key_wake_enable_reg && !status_reg[ST_START_BIT]
                                      |=> !status_reg[ST_START_BIT])
      else $error("start flag set with wake enable off");
   // Key-only wake: an idle slot end raises no wake request
   a_idle_quiet: assert property (cycle_end && !key_rise && !cfg_reg.wake_every_cycle_select
                                  && !status_reg[ST_WAKE_BIT] |=> !status_reg[ST_WAKE_BIT])
      else $error("idle scan cycle raised a wake request");
endmodule : key_matrix_scanner
`default_nettype wire

// ===== include/key_scan_pkg.sv
// Shared constants, register map and carrier types for the key matrix scanner.
// Assumes a 40 MHz system clock and a classic Wishbone register port.
`default_nettype none
package key_scan_pkg;
   // Clock and scan timing
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned FRAME_HZ_DEF  = 32;     // LCD frame frequency
   localparam int unsigned DUTY_DEF      = 5;      // Common phases of the duty setting
   localparam int unsigned SCAN_FACTOR   = 2;
   localparam int unsigned KEY_WINDOW_NS = 10_000; // Column drive time per scan cycle
   localparam int unsigned KEY_WINDOW_CYCLES = (KEY_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SCAN_CYCLES_DEF   = CLK_HZ / (FRAME_HZ_DEF * DUTY_DEF * SCAN_FACTOR);

   // Geometry
   localparam int unsigned NUM_COLUMNS = 16;
   localparam int unsigned NUM_ROWS    = 4;

   // Register byte addresses
   localparam logic [7:0] ADDR_CFG_IMM   = 8'h00;
   localparam logic [7:0] ADDR_CFG_NIB   = 8'h04;
   localparam logic [7:0] ADDR_CFG_TABLE = 8'h08;
   localparam logic [7:0] ADDR_ROW_LATCH = 8'h0c;
   localparam logic [7:0] ADDR_WAKE_EN   = 8'h10;
   localparam logic [7:0] ADDR_STATUS    = 8'h14;
   localparam logic [7:0] ADDR_MASK      = 8'h18;

   // Status and mask bit positions
   localparam int unsigned ST_START_BIT = 0;
   localparam int unsigned ST_SCAN_BIT  = 1;
   localparam int unsigned ST_WAKE_BIT  = 5;
   localparam int unsigned ST_WIDTH     = 6;
   localparam logic [ST_WIDTH-1:0] ST_IMPL = 6'h23;

   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h20;   // Scanning disabled

   // Column group modes (bit7, bit5, bit4)
   localparam logic [2:0] GRP_SINGLE = 3'h0;
   localparam logic [2:0] GRP_ALL    = 3'h1;
   localparam logic [2:0] GRP_OFF    = 3'h2;
   localparam logic [2:0] GRP_PAIR   = 3'h7;
   localparam logic [2:0] GRP_QUAD   = 3'h6;

   // Scan configuration byte
   typedef struct packed {
      logic       mode_hi;                 // Bit 7
      logic       wake_every_cycle_select; // Bit 6
      logic [1:0] mode_lo;                 // Bits 5:4
      logic [3:0] sel;                     // Bits 3:0
   } scan_cfg_s;

   // Wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } wb_req_s;

   // Column group mode of a configuration
   function automatic logic [2:0] column_group_mode(input scan_cfg_s c);
      return {c.mode_hi, c.mode_lo};
   endfunction : column_group_mode
endpackage : key_scan_pkg
`default_nettype wire

// ===== src/column_decode.sv
// Turns a scan configuration byte into the set of active scan columns.
// Pure combinational; the caller gates the result with the scan window.
`timescale 1ns/1ps
`default_nettype none
module column_decode
   import key_scan_pkg::*;
(
   // Configuration in
   input  wire scan_cfg_s              cfg_i,
   // Column set out
   output logic [NUM_COLUMNS-1:0]      columns_o,
   output logic                        scan_on_o
);
   // Mode decode; bit 4 is ignored when bits 7,5 are 10
   always_comb begin
      columns_o = '0;
      scan_on_o = 1'b1;
      if (cfg_i.mode_hi && !cfg_i.mode_lo[1]) begin
         columns_o = 16'h00ff << {cfg_i.sel[3], 3'h0};
      end else begin
         case (column_group_mode(cfg_i))
            GRP_SINGLE: columns_o = 16'h0001 << cfg_i.sel;
            GRP_ALL:    columns_o = 16'hffff;
            GRP_QUAD:   columns_o = 16'h000f << {cfg_i.sel[3:2], 2'h0};
            GRP_PAIR:   columns_o = 16'h0003 << {cfg_i.sel[3:1], 1'h0};
            default: begin
               columns_o = '0;
               scan_on_o = 1'b0;
            end
         endcase
      end
   end
endmodule : column_decode
`default_nettype wire

// ===== src/scan_timer.sv
// Scan cycle timer: one period per scan cycle, columns driven in a short
// window at its start. Assumes a free running system clock.
`timescale 1ns/1ps
`default_nettype none
module scan_timer #(
   parameter int unsigned PERIOD = 125_000,
   parameter int unsigned WINDOW = 400
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Timing out
   output logic      window_o,
   output logic      cycle_end_o
);
   localparam int unsigned CW = $clog2(PERIOD);
   localparam logic [CW-1:0] LAST     = CW'(PERIOD - 1);
   localparam logic [CW-1:0] WIN_LAST = CW'(WINDOW - 1);

   if (WINDOW < 1 || WINDOW >= PERIOD) begin : g_bad_window
      $error("scan window must be shorter than the scan period");
   end

   logic [CW-1:0] cnt_reg;

   // Period counter, wraps every scan cycle
   always_ff @(posedge clk_i) begin
      if (rst_i || cnt_reg == LAST) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   assign window_o    = (cnt_reg <= WIN_LAST);
   assign cycle_end_o = (cnt_reg == WIN_LAST);
endmodule : scan_timer
`default_nettype wire

// ===== bench/key_matrix_model.sv
// Passive key switch matrix on the far side of the scanner pins.
// Assumes rows are pulled low, so an open row reads 0.
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model (
   // Column lines and closed keys, sixteen per row
   input  wire logic [15:0] column_i,
   input  wire logic [63:0] pressed_i,
   // Row lines back to the scanner
   output logic [3:0]       row_o
);
   // A row sees every driven column through a closed key; the pull-down wins otherwise
   always_comb begin
      for (int r = 0; r < 4; r++) begin
         row_o[r] = |(column_i & pressed_i[r*16 +: 16]);
      end
   end
endmodule : key_matrix_model
`default_nettype wire

// ===== bench/key_matrix_scanner_tb.sv
// Self-checking bench for the key matrix scanner.
// Assumes the Wishbone map of the package and a shortened scan period.
`timescale 1ns/1ps
`default_nettype none
module key_matrix_scanner_tb;
   import key_scan_pkg::*;
   localparam int unsigned SCAN = 40;
   localparam int unsigned WIN  = 4;
   localparam logic [15:0] SEG  = 16'h5a3c; // Matches no column group
   typedef struct packed {logic [7:0] adr; logic [7:0] cfg; logic [15:0] cols;} case_s;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0]  sel_i = 4'h0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, rd, hits;
   logic        ack_o, halt_release_o, irq_o;
   logic [3:0]  row_i;
   logic [15:0] seg_lcd_i = SEG, column_o;
   logic [63:0] pressed = 64'h0;
   int          mismatches = 0, samples_checked = 0, n;
   case_s cases [11] = '{
      '{ADDR_CFG_IMM, 8'h00, 16'h0001}, '{ADDR_CFG_IMM, 8'h0f, 16'h8000},
      '{ADDR_CFG_NIB, 8'h0a, 16'h0400}, '{ADDR_CFG_TABLE, 8'h10, 16'hffff},
      '{ADDR_CFG_IMM, 8'h20, SEG}, '{ADDR_CFG_IMM, 8'h80, 16'h00ff},
      '{ADDR_CFG_NIB, 8'h98, 16'hff00}, '{ADDR_CFG_IMM, 8'ha4, 16'h00f0},
      '{ADDR_CFG_TABLE, 8'hac, 16'hf000}, '{ADDR_CFG_IMM, 8'hb0, 16'h0003},
      '{ADDR_CFG_IMM, 8'hbf, 16'hc000}};

   always #12.5 clk_i = ~clk_i;

   key_matrix_model matrix_u (.column_i(column_o), .pressed_i(pressed), .row_o(row_i));

   key_matrix_scanner #(.SCAN_CYCLES(SCAN), .WINDOW(WIN)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
      .row_i(row_i), .seg_lcd_i(seg_lcd_i), .column_o(column_o),
      .halt_release_o(halt_release_o), .irq_o(irq_o));

   // Verdict and end of run, shared by the main sequence and every timeout
   task automatic test_done;
      $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Classic single cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      int   k;
      logic seen;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      k = 0;
      // Ack is looked at mid-cycle, where it has settled, not at its own edge
      do begin
         @(negedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      seen = (ack_o === 1'b1);
      // The rising edge that samples ack high ends the request
      @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(negedge clk_i);
      if (!seen) begin
         mismatches++;
         $display("Error at %0t: bus request not acknowledged", $time);
         test_done();
      end
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, {24'h0, d}, 4'hf, rd);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      wb(1'b0, a, 32'h0, 4'hf, rd);
      chk(rd & {24'h0, m}, {24'h0, e});
   endtask : rdchk

   // Bounded wait for the halt release line
   task automatic wait_halt;
      n = 0;
      while (halt_release_o !== 1'b1 && n < 3*SCAN) begin
         @(negedge clk_i);
         n++;
      end
      if (halt_release_o !== 1'b1) begin
         mismatches++;
         $display("Error at %0t: halt release never came", $time);
         test_done();
      end
   endtask : wait_halt

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({16'h0, column_o}, {16'h0, SEG});
      chk({irq_o, halt_release_o}, 0);
      rdchk(ADDR_CFG_IMM, 8'hff, CFG_RESET);
      rdchk(ADDR_STATUS, 8'hff, 8'h00);
      // Unmapped place and a write without the low byte select are both ignored
      wr(8'h1c, 8'hff);
      rdchk(8'h1c, 8'hff, 8'h00);
      wb(1'b1, ADDR_CFG_IMM, 32'h10, 4'he, rd);
      rdchk(ADDR_CFG_IMM, 8'hff, CFG_RESET);
      // Scanning is first enabled here; the shared port lies outside this block
      // Every column group: one slot of WIN cycles per SCAN cycles, LCD data elsewhere
      foreach (cases[i]) begin
         wr(cases[i].adr, cases[i].cfg);
         rdchk(cases[i].adr, 8'hff, cases[i].cfg);
         repeat (SCAN) @(posedge clk_i);
         hits = 0;
         for (int c = 0; c < SCAN; c++) begin
            @(negedge clk_i);
            if (column_o === cases[i].cols) hits++;
            else chk({16'h0, column_o}, {16'h0, SEG});
         end
         chk(hits, (cases[i].cols === SEG) ? SCAN : WIN);
      end
      // Key press with wake enabled, then masking, latch and clear
      wr(ADDR_WAKE_EN, 8'h01);
      wr(ADDR_MASK, 8'h20);
      wr(ADDR_CFG_IMM, 8'h10);
      wr(ADDR_STATUS, 8'h23);
      pressed[2*16+4] <= 1'b1;
      wait_halt();
      chk(halt_release_o, 1);
      chk(irq_o, 1);
      rdchk(ADDR_STATUS, 8'h21, 8'h21);
      wr(ADDR_MASK, 8'h00);
      chk(irq_o, 0);
      repeat (SCAN) @(posedge clk_i);
      rdchk(ADDR_ROW_LATCH, 8'hff, 8'h04);
      pressed <= 64'h0;
      repeat (SCAN) @(posedge clk_i);
      wr(ADDR_STATUS, 8'h21);
      rdchk(ADDR_STATUS, 8'h21, 8'h00);
      chk(halt_release_o, 0);
      rdchk(ADDR_ROW_LATCH, 8'hff, 8'h00);
      // Key press without the enable: request only, no start flag, no release
      wr(ADDR_WAKE_EN, 8'h00);
      pressed[0*16+15] <= 1'b1;
      repeat (2*SCAN) @(posedge clk_i);
      rdchk(ADDR_STATUS, 8'h21, 8'h20);
      chk(halt_release_o, 0);
      pressed <= 64'h0;
      // Wake on every scan cycle with no key down
      wr(ADDR_WAKE_EN, 8'h01);
      wr(ADDR_CFG_IMM, 8'h50);
      wr(ADDR_STATUS, 8'h23);
      wait_halt();
      chk(halt_release_o, 1);
      rdchk(ADDR_STATUS, 8'h21, 8'h21);
      // Back to key-only wake: idle scan cycles raise no wake request and no start flag
      wr(ADDR_CFG_IMM, 8'h10);
      wr(ADDR_STATUS, 8'h23);
      repeat (2*SCAN) @(posedge clk_i);
      rdchk(ADDR_STATUS, 8'h21, 8'h00);
      // Clear and key event in one cycle: the new event must win. The clear is
      // timed to land in the first slot cycle, where a held key rises again
      pressed[2*16+0] <= 1'b1;
      n = 0;
      while (column_o === 16'hffff && n < 2*SCAN) begin
         @(negedge clk_i);
         n++;
      end
      while (column_o !== 16'hffff && n < 2*SCAN) begin
         @(negedge clk_i);
         n++;
      end
      if (column_o !== 16'hffff) begin
         mismatches++;
         $display("Error at %0t: scan slot not found", $time);
         test_done();
      end
      repeat (SCAN-2) @(posedge clk_i);
      wr(ADDR_STATUS, 8'h20);
      rdchk(ADDR_STATUS, 8'h20, 8'h20);
      // Reset in mid-run: registers and outputs back to idle
      pressed <= 64'h0;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({irq_o, halt_release_o}, 0);
      chk({16'h0, column_o}, {16'h0, SEG});
      rdchk(ADDR_STATUS, 8'hff, 8'h00);
      rdchk(ADDR_CFG_IMM, 8'hff, CFG_RESET);
      rdchk(ADDR_WAKE_EN, 8'hff, 8'h00);
      test_done();
   end
endmodule : key_matrix_scanner_tb
`default_nettype wire
